/* File: src/audio_smi_status.v */
/*
  Audio SMI status aggregation: second-level read-to-clear flags, their
  mirror, the I/O trap status with fast-path write capture, and the
  top-level SMI report. Assumes the channel enables, codec enables and
  trap enables come as levels from registers held elsewhere, and that
  the I/O decoder outside presents one trapped access per strobe.
*/
`include "audio_smi_regs.vh"

module audio_smi_status (
  input wire I_CLK,
  input wire I_RST_B,
  input wire I_REG_RD,
  input wire [`ADDR_W-1:0] I_REG_ADDR,
  input wire [5:0] I_BM_ENABLE,
  input wire [5:0] I_BM_END_OF_PAGE,
  input wire I_CODEC_SERIAL_INT,
  input wire I_CODEC_SERIAL_SMI_EN,
  input wire I_CODEC_GPIO_INT,
  input wire I_CODEC_GPIO_SMI_EN,
  input wire I_FAST_WRITE_EN,
  input wire I_SND_TRAP_EN,
  input wire I_DMA_LO_TRAP_EN,
  input wire I_DMA_HI_TRAP_EN,
  input wire I_MPU_LO_TRAP_EN,
  input wire I_MPU_HI_TRAP_EN,
  input wire I_IO_STB,
  input wire I_IO_WRITE,
  input wire [9:0] I_IO_ADDR,
  input wire [7:0] I_IO_DATA,
  input wire I_IO_FAST_ADDR,
  input wire I_IO_HIT_SND,
  input wire I_IO_HIT_DMA_LO,
  input wire I_IO_HIT_DMA_HI,
  input wire I_IO_HIT_MPU_LO,
  input wire I_IO_HIT_MPU_HI,
  output reg [31:0] O_REG_RDATA,
  output reg O_REG_RVALID,
  output reg O_TOP_SMI_STATUS,
  output reg O_SMI_REQ
);

  // --------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------
  reg rst_meta;
  reg rst_b;

  // Asynchronous assert, synchronous release
  always @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rst_meta <= 1'b0;
      rst_b <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_b <= rst_meta;
    end
  end

  // --------------------------------------------------------------------
  // Register read decode
  // --------------------------------------------------------------------
  wire rd_second = I_REG_RD & (I_REG_ADDR == `OFF_SECOND_STATUS);
  wire rd_mirror = I_REG_RD & (I_REG_ADDR == `OFF_SECOND_MIRROR);
  wire rd_trap = I_REG_RD & (I_REG_ADDR == `OFF_TRAP_STATUS);

  // --------------------------------------------------------------------
  // Fast-path write classification
  // --------------------------------------------------------------------
  wire io_wr = I_IO_STB & I_IO_WRITE;
  wire fast_wr = io_wr & I_FAST_WRITE_EN & I_IO_FAST_ADDR;
  wire fast_even = fast_wr & ~I_IO_ADDR[0];
  wire fast_odd = fast_wr & I_IO_ADDR[0];
  wire other_wr = io_wr & ~fast_wr;

  // --------------------------------------------------------------------
  // Trap causes
  // --------------------------------------------------------------------
  // Even fast writes raise no sound trap, so they cause no sound-trap SMI
  wire snd_trap = I_IO_STB & I_IO_HIT_SND & I_SND_TRAP_EN & ~fast_even;
  wire dma_trap = I_IO_STB & ((I_IO_HIT_DMA_LO & I_DMA_LO_TRAP_EN) |
                              (I_IO_HIT_DMA_HI & I_DMA_HI_TRAP_EN));
  wire mpu_trap = I_IO_STB & ((I_IO_HIT_MPU_LO & I_MPU_LO_TRAP_EN) |
                              (I_IO_HIT_MPU_HI & I_MPU_HI_TRAP_EN));
  wire any_trap = snd_trap | dma_trap | mpu_trap;

  reg [`TRAP_FLAG_W-1:0] trap_set;

  always @* begin
    trap_set = `TRAP_FLAG_RESET;
    trap_set[`TRAP_F_SND_FAST] = snd_trap & I_FAST_WRITE_EN;
    trap_set[`TRAP_F_SND] = snd_trap & ~I_FAST_WRITE_EN;
    trap_set[`TRAP_F_DMA] = dma_trap;
    trap_set[`TRAP_F_MPU] = mpu_trap;
  end

  // --------------------------------------------------------------------
  // Second-level event sources
  // --------------------------------------------------------------------
  reg [`SEC_W-1:0] sec_set;

  // Channel n lands at bit n+2: bits 2..7 for channels 0..5
  always @* begin
    sec_set = `SEC_RESET;
    sec_set[`SEC_BM_HI:`SEC_BM_LO] = I_BM_ENABLE & I_BM_END_OF_PAGE;
    sec_set[`SEC_CODEC] = (I_CODEC_SERIAL_INT & I_CODEC_SERIAL_SMI_EN) |
                          (I_CODEC_GPIO_INT & I_CODEC_GPIO_SMI_EN);
    sec_set[`SEC_TRAP] = any_trap;
  end

  // --------------------------------------------------------------------
  // Sticky flag banks
  // --------------------------------------------------------------------
  wire [`SEC_W-1:0] sec_flags;
  wire [`SEC_W-1:0] sec_next;
  wire [`TRAP_FLAG_W-1:0] trap_flags;

  sticky_flags #(
    .WIDTH(`SEC_W)
  ) u_second (
    .clk(I_CLK),
    .rst_b(rst_b),
    .i_set(sec_set),
    .i_clear(rd_second),
    .o_flags(sec_flags),
    .o_next(sec_next)
  );

  sticky_flags #(
    .WIDTH(`TRAP_FLAG_W)
  ) u_trap (
    .clk(I_CLK),
    .rst_b(rst_b),
    .i_set(trap_set),
    .i_clear(rd_trap),
    .o_flags(trap_flags),
    .o_next()
  );

  // --------------------------------------------------------------------
  // Trap capture fields
  // --------------------------------------------------------------------
  reg [7:0] even_data;
  reg [7:0] odd_data;
  reg fast_a1;
  reg last_dir;
  reg [9:0] xaddr;

  always @(posedge I_CLK or negedge rst_b) begin
    if (!rst_b) begin
      even_data <= `BYTE_RESET;
      odd_data <= `BYTE_RESET;
      fast_a1 <= 1'b0;
      last_dir <= 1'b0;
      xaddr <= `XADDR_RESET;
    end else begin
      if (fast_even) begin
        even_data <= I_IO_DATA;
      end
      if (fast_odd | other_wr) begin
        odd_data <= I_IO_DATA;
      end
      if (fast_wr) begin
        fast_a1 <= I_IO_ADDR[1];
      end
      if (any_trap) begin
        last_dir <= I_IO_WRITE;
        xaddr <= I_IO_ADDR;
      end
    end
  end

  wire [31:0] trap_word = {even_data, odd_data, fast_a1, last_dir, trap_flags, xaddr};

  // --------------------------------------------------------------------
  // Read data and SMI outputs
  // --------------------------------------------------------------------
  // Read data shows the flags as they stood before the clear takes hold
  reg [31:0] next_rdata;

  always @* begin
    next_rdata = `RDATA_RESET;
    if (rd_second | rd_mirror) begin
      next_rdata[`SEC_W-1:0] = sec_flags;
    end else if (rd_trap) begin
      next_rdata = trap_word;
    end
  end

  always @(posedge I_CLK or negedge rst_b) begin
    if (!rst_b) begin
      O_REG_RDATA <= `RDATA_RESET;
      O_REG_RVALID <= 1'b0;
      O_TOP_SMI_STATUS <= 1'b0;
      O_SMI_REQ <= 1'b0;
    end else begin
      O_REG_RDATA <= next_rdata;
      O_REG_RVALID <= I_REG_RD;
      // Taken from the next flag value, so both outputs line up with the flag register
      O_TOP_SMI_STATUS <= |sec_next;
      O_SMI_REQ <= |sec_next;
    end
  end

endmodule

/* File: include/audio_smi_regs.vh */
/*
  Register offsets, field positions and reset values of the audio SMI
  status block. Assumes byte offsets within the audio register window
  and 8-bit wide status bytes packed into the windows below.
*/
`ifndef AUDIO_SMI_REGS_VH
`define AUDIO_SMI_REGS_VH

// ----------------------------------------------------------------------
// Register offsets inside the audio block window
// ----------------------------------------------------------------------
`define ADDR_W 7
`define OFF_SECOND_STATUS 7'h10
`define OFF_SECOND_MIRROR 7'h12
`define OFF_TRAP_STATUS 7'h14

// ----------------------------------------------------------------------
// Second-level status layout
// ----------------------------------------------------------------------
`define SEC_W 8
`define SEC_TRAP 0
`define SEC_CODEC 1
`define SEC_BM_LO 2
`define SEC_BM_HI 7
`define SEC_RESET 8'h00
`define BM_CHANNELS 6

// ----------------------------------------------------------------------
// Trap status layout
// ----------------------------------------------------------------------
`define TRAP_EVEN_HI 31
`define TRAP_EVEN_LO 24
`define TRAP_ODD_HI 23
`define TRAP_ODD_LO 16
`define TRAP_A1 15
`define TRAP_DIR 14
`define TRAP_FLAG_HI 13
`define TRAP_FLAG_LO 10
`define TRAP_XADDR_HI 9
`define TRAP_XADDR_LO 0
`define TRAP_FLAG_W 4
`define TRAP_F_SND_FAST 3
`define TRAP_F_DMA 2
`define TRAP_F_MPU 1
`define TRAP_F_SND 0
`define TRAP_FLAG_RESET 4'h0
`define BYTE_RESET 8'h00
`define XADDR_RESET 10'h000
`define RDATA_RESET 32'h00000000

`endif

/* File: src/sticky_flags.v */
/*
  Bank of sticky event flags with a common clear strobe.
  Assumes set and clear are synchronous to clk and reset is already
  synchronised by the instantiating module.
*/
module sticky_flags #(
  parameter WIDTH = 8
) (
  input wire clk,
  input wire rst_b,
  input wire [WIDTH-1:0] i_set,
  input wire i_clear,
  output wire [WIDTH-1:0] o_flags,
  output wire [WIDTH-1:0] o_next
);

  // --------------------------------------------------------------------
  // One flag per bit
  // --------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : bit_slice
      reg flag;
      // Set beats clear so an event during the clearing read survives
      wire next_flag = i_set[g] | (flag & ~i_clear);
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          flag <= 1'b0;
        end else begin
          flag <= next_flag;
        end
      end
      assign o_flags[g] = flag;
      assign o_next[g] = next_flag;
    end
  endgenerate

endmodule

/* File: testbench/audio_smi_status_assertions.sv */
/* Checker of the audio SMI status block, watching its top ports.
   Assumes one clock and the asynchronous active-low reset. */
`include "audio_smi_regs.vh"
module audio_smi_checker (
  input wire I_CLK, I_RST_B, I_REG_RD,
  input wire [`ADDR_W-1:0] I_REG_ADDR,
  input wire [5:0] I_BM_ENABLE, I_BM_END_OF_PAGE,
  input wire I_CODEC_SERIAL_INT, I_CODEC_SERIAL_SMI_EN, I_CODEC_GPIO_INT, I_IO_STB,
  input wire [31:0] O_REG_RDATA,
  input wire O_REG_RVALID, O_TOP_SMI_STATUS, O_SMI_REQ
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);
  wire bm_ev = |(I_BM_ENABLE & I_BM_END_OF_PAGE);
  // No source may set a flag in this cycle
  wire quiet = !bm_ev && !I_CODEC_SERIAL_INT && !I_CODEC_GPIO_INT && !I_IO_STB;
  wire rd_sec = I_REG_RD && I_REG_ADDR == `OFF_SECOND_STATUS;
  bm_to_smi_a: assert property (bm_ev |=> O_SMI_REQ)
    else $error("channel event without SMI");
  codec_to_smi_a: assert property (I_CODEC_SERIAL_INT && I_CODEC_SERIAL_SMI_EN |=> O_SMI_REQ)
    else $error("codec event without SMI");
  top_match_a: assert property (O_TOP_SMI_STATUS == O_SMI_REQ)
    else $error("top status differs from SMI");
  read_answer_a: assert property (I_REG_RD |=> O_REG_RVALID)
    else $error("read not answered");
  idle_bus_a: assert property (!I_REG_RD |=> !O_REG_RVALID && O_REG_RDATA == 32'h0)
    else $error("data without read");
  clear_drops_a: assert property (rd_sec && quiet |=> !O_SMI_REQ)
    else $error("SMI kept after clearing read");
  mirror_keeps_a: assert property (O_SMI_REQ && I_REG_RD && I_REG_ADDR == `OFF_SECOND_MIRROR
    |=> O_SMI_REQ)
    else $error("mirror read dropped SMI");
  smi_holds_a: assert property (O_SMI_REQ && !rd_sec |=> O_SMI_REQ)
    else $error("SMI dropped without clear");
  no_cause_a: assert property (!O_SMI_REQ && quiet |=> !O_SMI_REQ)
    else $error("SMI without cause");
  pad_zero_a: assert property (I_REG_RD && I_REG_ADDR != `OFF_TRAP_STATUS
    |=> O_REG_RDATA[31:8] == 24'h0)
    else $error("upper read bits set");
  cover property (bm_ev ##1 rd_sec);
  cover property (rd_sec && bm_ev);
  cover property (I_IO_STB ##1 O_SMI_REQ);
endmodule
bind audio_smi_status audio_smi_checker chk (.I_CLK, .I_RST_B, .I_REG_RD, .I_REG_ADDR,
  .I_BM_ENABLE, .I_BM_END_OF_PAGE, .I_CODEC_SERIAL_INT, .I_CODEC_SERIAL_SMI_EN,
  .I_CODEC_GPIO_INT, .I_IO_STB, .O_REG_RDATA, .O_REG_RVALID, .O_TOP_SMI_STATUS, .O_SMI_REQ);

/* File: testbench/smi_host.sv */
/* Host side model: reads the status registers through the strobe port.
   Assumes callers enter read at a falling clock edge. */
`include "audio_smi_regs.vh"
module smi_host (
  input wire logic clk,
  input wire logic rvalid,
  input wire logic [31:0] rdata,
  output logic rd,
  output logic [`ADDR_W-1:0] addr
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    rd = 1'b0;
    addr = '0;
  end
  // Bounded wait; unknown data marks a missing answer
  task automatic read(input logic [`ADDR_W-1:0] a, output logic [31:0] d);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    addr = ~a;
    d = 'x;
    for (int i = 0; i < 4; i++) begin
      if (rvalid === 1'b1) begin
        d = rdata;
        break;
      end
      @(negedge clk);
    end
    // Let an edge pass so a following read never re-raises the strobe at once
    @(negedge clk);
  endtask
endmodule

/* File: testbench/test_audio_smi_status.sv */
/* Self-checking bench of the audio SMI status block.
   Assumes the host model drives the register port. */
`include "audio_smi_regs.vh"
module test_audio_smi_status;
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // Stimulus and instances
  // ------------------------------------------------------------
  logic I_CLK = 0, I_RST_B = 0, I_FAST_WRITE_EN = 0, I_SND_TRAP_EN = 0;
  logic [5:0] I_BM_ENABLE = 0, I_BM_END_OF_PAGE = 0;
  logic I_CODEC_SERIAL_INT = 0, I_CODEC_SERIAL_SMI_EN = 0, I_CODEC_GPIO_INT = 0;
  logic I_CODEC_GPIO_SMI_EN = 0, I_DMA_LO_TRAP_EN = 0, I_DMA_HI_TRAP_EN = 0;
  logic I_MPU_LO_TRAP_EN = 0, I_MPU_HI_TRAP_EN = 0, I_IO_STB = 0, I_IO_WRITE = 0;
  logic I_IO_FAST_ADDR = 0, I_IO_HIT_SND = 0, I_IO_HIT_DMA_LO = 0, I_IO_HIT_DMA_HI = 0;
  logic I_IO_HIT_MPU_LO = 0, I_IO_HIT_MPU_HI = 0;
  logic [9:0] I_IO_ADDR = 0;
  logic [7:0] I_IO_DATA = 0;
  wire I_REG_RD;
  wire [`ADDR_W-1:0] I_REG_ADDR;
  wire [31:0] O_REG_RDATA;
  wire O_REG_RVALID, O_TOP_SMI_STATUS, O_SMI_REQ;
  int mismatches = 0, cmp_count = 0;
  logic [31:0] d;
  audio_smi_status dut (.*);
  smi_host host (.clk(I_CLK), .rvalid(O_REG_RVALID), .rdata(O_REG_RDATA), .rd(I_REG_RD),
    .addr(I_REG_ADDR));
  always #50 I_CLK = ~I_CLK;
  task check(input string what, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task final_report;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_reset;
    logic [`ADDR_W-1:0] offs[4] = '{`OFF_SECOND_STATUS, `OFF_SECOND_MIRROR, `OFF_TRAP_STATUS, 7'h7c};
    foreach (offs[i]) begin
      host.read(offs[i], d);
      check("reset value", d, 32'h0);
    end
    $display("test reset done");
  endtask
  task t_bm;
    for (int n = 0; n < 6; n++) begin
      I_BM_ENABLE = 6'h01 << n;
      I_BM_END_OF_PAGE = 6'h3f;
      @(negedge I_CLK);
      I_BM_END_OF_PAGE = 6'h00;
      host.read(`OFF_SECOND_MIRROR, d);
      check("mirror", d, 32'h4 << n);
      check("top", {31'h0, O_TOP_SMI_STATUS}, 32'h1);
      host.read(`OFF_SECOND_STATUS, d);
      check("status", d, 32'h4 << n);
      host.read(`OFF_SECOND_STATUS, d);
      check("cleared", d, 32'h0);
      check("smi off", {31'h0, O_SMI_REQ}, 32'h0);
    end
    $display("test channels done");
  endtask
  task t_codec;
    for (int k = 0; k < 3; k++) begin
      {I_CODEC_SERIAL_SMI_EN, I_CODEC_GPIO_SMI_EN} = k[1:0];
      {I_CODEC_SERIAL_INT, I_CODEC_GPIO_INT} = 2'b11;
      @(negedge I_CLK);
      {I_CODEC_SERIAL_INT, I_CODEC_GPIO_INT} = 2'b00;
      host.read(`OFF_SECOND_STATUS, d);
      check("codec", d, (k != 0) ? 32'h2 : 32'h0);
    end
    $display("test codec done");
  endtask
  task t_race;
    I_BM_ENABLE = 6'h01;
    I_BM_END_OF_PAGE = 6'h01;
    @(negedge I_CLK);
    // Event still high at the clearing read's edge
    host.read(`OFF_SECOND_STATUS, d);
    I_BM_END_OF_PAGE = 6'h00;
    check("race read", d, 32'h4);
    check("race smi", {31'h0, O_SMI_REQ}, 32'h1);
    host.read(`OFF_SECOND_STATUS, d);
    check("race kept", d, 32'h4);
    $display("test race done");
  endtask
  task trap(input logic w, f, input logic [9:0] a, input logic [7:0] dt, input logic [4:0] hit,
    input logic [31:0] exp, mask, input logic [7:0] sec);
    {I_IO_STB, I_IO_WRITE, I_IO_FAST_ADDR, I_IO_ADDR, I_IO_DATA} = {1'b1, w, f, a, dt};
    {I_IO_HIT_SND, I_IO_HIT_DMA_LO, I_IO_HIT_DMA_HI, I_IO_HIT_MPU_LO, I_IO_HIT_MPU_HI} = hit;
    @(negedge I_CLK);
    {I_IO_STB, I_IO_ADDR, I_IO_DATA} = {1'b0, ~a, ~dt};
    {I_IO_HIT_SND, I_IO_HIT_DMA_LO, I_IO_HIT_DMA_HI, I_IO_HIT_MPU_LO, I_IO_HIT_MPU_HI} = 5'h0;
    host.read(`OFF_TRAP_STATUS, d);
    check("trap word", d & mask, exp);
    host.read(`OFF_SECOND_STATUS, d);
    check("trap level", d, {24'h0, sec});
  endtask
  task t_trap;
    {I_SND_TRAP_EN, I_DMA_LO_TRAP_EN, I_DMA_HI_TRAP_EN, I_MPU_LO_TRAP_EN, I_MPU_HI_TRAP_EN} = '1;
    trap(0, 0, 10'h220, 8'h00, 5'h10, 32'h00000620, '1, 8'h1);
    trap(1, 0, 10'h00c, 8'h5a, 5'h08, 32'h005a500c, '1, 8'h1);
    trap(1, 0, 10'h331, 8'h11, 5'h01, 32'h00114b31, '1, 8'h1);
    I_FAST_WRITE_EN = 1;
    trap(1, 1, 10'h38b, 8'ha5, 5'h10, 32'h00a5e38b, '1, 8'h1);
    trap(1, 1, 10'h388, 8'h3c, 5'h10, 32'h3ca50000, 32'hffffbc00, 8'h0);
    trap(1, 0, 10'h301, 8'h77, 5'h02, 32'h3c774b01, '1, 8'h1);
    trap(0, 0, 10'h0c0, 8'h00, 5'h04, 32'h3c7710c0, '1, 8'h1);
    I_SND_TRAP_EN = 0;
    trap(0, 0, 10'h230, 8'h00, 5'h10, 32'h0, 32'h00003c00, 8'h0);
    $display("test traps done");
  endtask
  initial begin
    repeat (10) @(negedge I_CLK);
    I_RST_B = 1;
    repeat (3) @(negedge I_CLK);
    t_reset;
    t_bm;
    t_codec;
    t_race;
    t_trap;
    final_report;
  end
  // Hang guard
  initial begin
    repeat (5000) @(posedge I_CLK);
    mismatches++;
    final_report;
  end
endmodule
